// *** hdl/nvmc_regs.svh ***
// register offsets, field positions and timing constants of the nvm control unit
`ifndef NVMC_REGS_SVH
`define NVMC_REGS_SVH
`define NVMC_OFF_CONTROL 3'h0
`define NVMC_OFF_UNLOCK 3'h1
`define NVMC_OFF_ADDR_LO 3'h2
`define NVMC_OFF_ADDR_HI 3'h3
`define NVMC_OFF_DATA 3'h4
`define NVMC_BIT_REGION_HI 7
`define NVMC_BIT_REGION_LO 6
`define NVMC_BIT_ERASE 4
`define NVMC_BIT_WERR 3
`define NVMC_BIT_WRITE_ENABLE_BIT 2
`define NVMC_BIT_WR 1
`define NVMC_BIT_RD 0
`define NVMC_KEY_FIRST 8'h55
`define NVMC_KEY_SECOND 8'hAA
`define NVMC_ADDR_HI_MASK 8'h03
`define NVMC_ZERO_BYTE 8'h00
`define NVMC_PROG_CYCLES 16'h0100
`define NVMC_PWRT_CYCLES 16'h0400
`endif

// *** hdl/nvmc_pkg.sv ***
// types shared by the nvm control unit
package nvmc_pkg;
   typedef enum logic [1:0] {
      NVMC_REGION_DATA,
      NVMC_REGION_FLASH,
      NVMC_REGION_INFO
   } nvmc_region_t;
   typedef enum logic [1:0] {
      NVMC_KEY_IDLE,
      NVMC_KEY_GOT_FIRST,
      NVMC_KEY_ARMED
   } nvmc_key_t;
endpackage

// *** hdl/nvmc_unlock_if.sv ***
// carrier between unlock tracker and control core
`timescale 1ns/1ps
interface nvmc_unlock_if;
   logic keyWrite;
   logic [7:0] keyData;
   logic otherWrite;
   logic consume;
   logic armed;
   modport tracker (input keyWrite, input keyData, input otherWrite, input consume,
      output armed);
   modport core (output keyWrite, output keyData, output otherWrite, output consume,
      input armed);
endinterface

// *** hdl/nvmc_unlock.sv ***
// unlock key sequence tracker
`timescale 1ns/1ps
`include "nvmc_regs.svh"
module nvmc_unlock (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // carrier
   nvmc_unlock_if.tracker lk
);
   import nvmc_pkg::*;
   nvmc_key_t state_q;
   nvmc_key_t state_d;
   always_comb begin
      state_d = state_q;
      if (lk.consume || lk.otherWrite) begin
         state_d = NVMC_KEY_IDLE;
      end else if (lk.keyWrite) begin
         unique case (state_q)
            NVMC_KEY_IDLE: state_d = (lk.keyData == `NVMC_KEY_FIRST) ?
               NVMC_KEY_GOT_FIRST : NVMC_KEY_IDLE;
            NVMC_KEY_GOT_FIRST: state_d = (lk.keyData == `NVMC_KEY_SECOND) ?
               NVMC_KEY_ARMED : NVMC_KEY_IDLE;
            NVMC_KEY_ARMED: state_d = (lk.keyData == `NVMC_KEY_FIRST) ?
               NVMC_KEY_GOT_FIRST : NVMC_KEY_IDLE;
            default: state_d = NVMC_KEY_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= NVMC_KEY_IDLE;
      end else begin
         state_q <= state_d;
      end
   end
   assign lk.armed = (state_q == NVMC_KEY_ARMED);
endmodule

// *** hdl/nvmc_timer.sv ***
// self-timed operation counter
`timescale 1ns/1ps
module nvmc_timer #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic start,
   input wire logic [WIDTH-1:0] length,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] count_q;
   logic busy_q;
   logic done_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= busy_q && (count_q == WIDTH'(1));
         if (start && !busy_q) begin
            count_q <= length;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            count_q <= count_q - WIDTH'(1);
            busy_q <= (count_q != WIDTH'(1));
         end
      end
   end
   assign busy = busy_q;
   assign done = done_q;
endmodule

// *** hdl/nvmc_control.sv ***
`timescale 1ns/1ps
`include "nvmc_regs.svh"
module nvmc_control #(
   parameter int PROG_CYCLES = `NVMC_PROG_CYCLES,
   parameter int PWRT_CYCLES = `NVMC_PWRT_CYCLES,
   parameter int ADDR_W = 10
) (
   // clock and resets
   input wire logic clk,
   input wire logic nrst,
   input wire logic porNrst,
   // special function register port
   input wire logic [2:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // array port
   output logic [ADDR_W-1:0] arrAddr,
   output logic [1:0] arrRegion,
   output logic arrReadStb,
   input wire logic [7:0] arrRdata,
   output logic arrProgStb,
   output logic arrEraseStb,
   output logic [7:0] arrWdata,
   input wire logic addrInvalid,
   input wire logic addrProtected,
   input wire logic regionMismatch,
   // status
   output logic nvmDoneIrqFlag,
   input wire logic irqFlagClear,
   output logic writeBusy
);
   import nvmc_pkg::*;
   nvmc_unlock_if lk ();
   logic [1:0] region_q;
   logic erase_q;
   logic write_enable_bit_q;
   logic wr_q;
   logic werr_q;
   logic [7:0] addrLo_q;
   logic [1:0] addrHi_q;
   logic [7:0] data_q;
   logic [7:0] rdata_q;
   logic readStb_q;
   logic progStb_q;
   logic eraseStb_q;
   logic irq_q;
   logic [15:0] pwrt_q;
   logic wrActive_q;
   logic timerBusy;
   logic timerDone;
   logic wrCtl;
   logic wrKey;
   logic wrALo;
   logic wrAHi;
   logic wrDat;
   logic pwrtRunning;
   logic wantWr;
   logic wrAllowed;
   logic wrFault;
   logic wrGo;
   logic wantRd;
   logic rdGo;
   logic eraseSel;
   logic locked;
   nvmc_region_t region;
   logic [7:0] ctlView;
   logic [7:0] rdMux;

   function automatic nvmc_region_t decodeRegion(input logic [1:0] sel);
      if (sel[0]) begin
         return NVMC_REGION_INFO;
      end
      return sel[1] ? NVMC_REGION_FLASH : NVMC_REGION_DATA;
   endfunction

   assign locked = wr_q;
   assign wrCtl = regWrite && (regAddr == `NVMC_OFF_CONTROL);
   assign wrKey = regWrite && (regAddr == `NVMC_OFF_UNLOCK);
   assign wrALo = regWrite && (regAddr == `NVMC_OFF_ADDR_LO) && !locked;
   assign wrAHi = regWrite && (regAddr == `NVMC_OFF_ADDR_HI) && !locked;
   assign wrDat = regWrite && (regAddr == `NVMC_OFF_DATA) && !locked;
   // region and erase select as carried by the control write itself
   assign region = decodeRegion(regWdata[`NVMC_BIT_REGION_HI:`NVMC_BIT_REGION_LO]);
   assign eraseSel = (region == NVMC_REGION_FLASH) && regWdata[`NVMC_BIT_ERASE];
   assign pwrtRunning = (pwrt_q != 16'h0000);
   // write-start request needs prior enable, not one set in this same write
   assign wantWr = wrCtl && !locked && regWdata[`NVMC_BIT_WR];
   assign wrAllowed = write_enable_bit_q && lk.armed && !pwrtRunning;
   assign wrFault = addrInvalid || addrProtected || regionMismatch;
   assign wrGo = wantWr && wrAllowed && !wrFault;
   assign wantRd = wrCtl && !locked && regWdata[`NVMC_BIT_RD];
   assign rdGo = wantRd && !wantWr && (region != NVMC_REGION_FLASH);

   assign lk.keyWrite = wrKey;
   assign lk.keyData = regWdata;
   assign lk.otherWrite = regWrite && !wrKey && !wantWr;
   assign lk.consume = wantWr;

   nvmc_unlock u_unlock (
      .clk(clk),
      .nrst(nrst),
      .lk(lk)
   );

   nvmc_timer #(.WIDTH(16)) u_timer (
      .clk(clk),
      .nrst(nrst),
      .start(wrGo),
      .length(16'(PROG_CYCLES)),
      .busy(timerBusy),
      .done(timerDone)
   );

   assign ctlView = {region_q, 1'b0, erase_q, werr_q, write_enable_bit_q, wr_q, readStb_q};
   assign rdMux = (regAddr == `NVMC_OFF_CONTROL) ? ctlView :
      (regAddr == `NVMC_OFF_UNLOCK) ? `NVMC_ZERO_BYTE :
      (regAddr == `NVMC_OFF_ADDR_LO) ? addrLo_q :
      (regAddr == `NVMC_OFF_ADDR_HI) ? {6'h00, addrHi_q} :
      (regAddr == `NVMC_OFF_DATA) ? data_q : `NVMC_ZERO_BYTE;

   // power-up timer
   always_ff @(posedge clk or negedge porNrst) begin
      if (!porNrst) begin
         pwrt_q <= 16'(PWRT_CYCLES);
      end else if (pwrtRunning) begin
         pwrt_q <= pwrt_q - 16'h0001;
      end
   end

   // write-error flag, power-on reset domain only
   always_ff @(posedge clk or negedge porNrst) begin
      if (!porNrst) begin
         werr_q <= 1'b0;
      end else if (!nrst && wrActive_q) begin
         werr_q <= 1'b1;
      end else if (wantWr && wrAllowed && wrFault) begin
         werr_q <= 1'b1;
      end else if (wrCtl && !locked) begin
         werr_q <= regWdata[`NVMC_BIT_WERR];
      end
   end

   // a write caught by reset is remembered across the reset
   always_ff @(posedge clk or negedge porNrst) begin
      if (!porNrst) begin
         wrActive_q <= 1'b0;
      end else if (nrst) begin
         wrActive_q <= wr_q;
      end else begin
         wrActive_q <= 1'b0;
      end
   end

   // control fields
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         region_q <= 2'b00;
         erase_q <= 1'b0;
         write_enable_bit_q <= 1'b0;
      end else if (wrCtl && !locked) begin
         region_q <= regWdata[`NVMC_BIT_REGION_HI:`NVMC_BIT_REGION_LO];
         erase_q <= regWdata[`NVMC_BIT_ERASE];
         write_enable_bit_q <= regWdata[`NVMC_BIT_WRITE_ENABLE_BIT];
      end
   end

   // write-start and completion
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= 1'b0;
         irq_q <= 1'b0;
         progStb_q <= 1'b0;
         eraseStb_q <= 1'b0;
      end else begin
         progStb_q <= wrGo && !eraseSel;
         eraseStb_q <= wrGo && eraseSel;
         if (wrGo) begin
            wr_q <= 1'b1;
         end else if (timerDone) begin
            wr_q <= 1'b0;
         end
         if (timerDone) begin
            irq_q <= 1'b1;
         end else if (irqFlagClear) begin
            irq_q <= 1'b0;
         end
      end
   end

   // address, data and read path
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addrLo_q <= 8'h00;
         addrHi_q <= 2'b00;
         data_q <= 8'h00;
         readStb_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         readStb_q <= rdGo;
         rdata_q <= regRead ? rdMux : rdata_q;
         if (wrALo) begin
            addrLo_q <= regWdata;
         end
         if (wrAHi) begin
            addrHi_q <= 2'(regWdata & `NVMC_ADDR_HI_MASK);
         end
         if (readStb_q) begin
            data_q <= arrRdata;
         end else if (wrDat) begin
            data_q <= regWdata;
         end
      end
   end

   assign regRdata = rdata_q;
   assign arrAddr = ADDR_W'({addrHi_q, addrLo_q});
   assign arrRegion = region_q;
   assign arrReadStb = readStb_q;
   assign arrProgStb = progStb_q;
   assign arrEraseStb = eraseStb_q;
   assign arrWdata = data_q;
   assign nvmDoneIrqFlag = irq_q;
   assign writeBusy = wr_q;

   // write launch: accepted start, one strobe with busy up, then no second strobe
   sequence launchReq_s;
      wrGo;
   endsequence
   sequence launchAck_s;
      (arrProgStb ^ arrEraseStb) && writeBusy && !timerDone;
   endsequence
   sequence launchTail_s;
      !arrProgStb && !arrEraseStb && writeBusy;
   endsequence

   // checks of the register, read and write paths
   wrgo_needs_write_enable_bit_a: assert property (@(posedge clk) disable iff (!nrst)
      wrGo |-> write_enable_bit_q && lk.armed) else $error("write began without enable or unlock");
   no_wr_pwrt_a: assert property (@(posedge clk) disable iff (!nrst)
      pwrtRunning |-> !wrGo) else $error("write during power-up period");
   wr_clears_done_a: assert property (@(posedge clk) disable iff (!nrst)
      timerDone |=> !wr_q && irq_q) else $error("completion did not clear start");
   wr_holds_a: assert property (@(posedge clk) disable iff (!nrst)
      wr_q && !timerDone |=> wr_q) else $error("write-start dropped early");
   unlock_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      regRead && regAddr == `NVMC_OFF_UNLOCK |=> regRdata == `NVMC_ZERO_BYTE)
      else $error("unlock register read nonzero");
   read_load_a: assert property (@(posedge clk) disable iff (!nrst)
      rdGo |=> ##1 data_q == $past(arrRdata)) else $error("read data not loaded");
   werr_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      werr_q && !wrCtl |=> werr_q) else $error("error flag cleared by hardware");
   lock_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      wr_q && !timerDone |=> $stable(addrLo_q) && $stable(data_q))
      else $error("address or data changed during write");
   hi_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      regRead && regAddr == `NVMC_OFF_ADDR_HI |=> regRdata[7:2] == 6'h00)
      else $error("address high reserved bits nonzero");
   start_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
      launchReq_s |=> launchAck_s) else $error("accepted start gave no strobe or busy");
   strobe_once_a: assert property (@(posedge clk) disable iff (!nrst)
      launchReq_s ##1 launchAck_s |=> launchTail_s) else $error("start strobe repeated");
   no_write_enable_bit_start_a: assert property (@(posedge clk) disable iff (!nrst)
      wantWr && !write_enable_bit_q |=> !writeBusy) else $error("start taken without prior enable");
   write_enable_bit_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> !write_enable_bit_q && !writeBusy) else $error("enable or start set after reset");
   fault_no_start_a: assert property (@(posedge clk) disable iff (!nrst)
      wantWr && wrFault |=> !writeBusy) else $error("faulty start was taken");
   fault_flag_a: assert property (@(posedge clk) disable iff (!nrst)
      wantWr && wrAllowed && wrFault |=> werr_q) else $error("fault did not set error flag");
   rd_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
      rdGo |=> arrReadStb && !writeBusy) else $error("read start gave no strobe");
   flash_no_read_a: assert property (@(posedge clk) disable iff (!nrst)
      arrReadStb |-> decodeRegion(arrRegion) != NVMC_REGION_FLASH)
      else $error("read strobe for program flash");
   erase_flash_a: assert property (@(posedge clk) disable iff (!nrst)
      arrEraseStb |-> decodeRegion(arrRegion) == NVMC_REGION_FLASH)
      else $error("erase strobe outside program flash");
   irq_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      irq_q && !irqFlagClear |=> irq_q) else $error("done flag cleared without request");
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the nvm control unit
`timescale 1ns/1ps
module tb_top;
   localparam int PROG = 8;
   localparam int PWRT = 40;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic porNrst = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regWdata = 8'h00;
   logic [7:0] regRdata, arrWdata;
   logic [7:0] arrRdata = 8'h00;
   logic [9:0] arrAddr;
   logic [1:0] arrRegion;
   logic arrReadStb, arrProgStb, arrEraseStb, nvmDoneIrqFlag, writeBusy;
   logic [2:0] fault = 3'h0;
   logic irqFlagClear = 1'b0;
   int mismatches = 0;
   int checks = 0;
   int progCnt = 0;
   int eraseCnt = 0;
   int readCnt = 0;
   int seed = 32'h8dd5;
   int cyc;
   logic [7:0] v, d;
   logic [9:0] a;

   nvmc_control #(.PROG_CYCLES(PROG), .PWRT_CYCLES(PWRT)) u_nvmc_control (
      .clk(clk), .nrst(nrst), .porNrst(porNrst), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .arrAddr(arrAddr),
      .arrRegion(arrRegion), .arrReadStb(arrReadStb), .arrRdata(arrRdata),
      .arrProgStb(arrProgStb), .arrEraseStb(arrEraseStb), .arrWdata(arrWdata),
      .addrInvalid(fault[0]), .addrProtected(fault[1]), .regionMismatch(fault[2]),
      .nvmDoneIrqFlag(nvmDoneIrqFlag), .irqFlagClear(irqFlagClear), .writeBusy(writeBusy));

   always #12.5 clk = ~clk;

   function automatic logic [7:0] memf(input logic [9:0] x);
      return x[7:0] ^ {x[9:8], 6'h15};
   endfunction

   // registered array model and strobe counters
   always @(posedge clk) begin
      arrRdata <= memf(arrAddr);
      if (arrProgStb === 1'b1) progCnt++;
      if (arrEraseStb === 1'b1) eraseCnt++;
      if (arrReadStb === 1'b1) readCnt++;
   end

   task automatic chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
      @(posedge clk);
      regAddr <= ad;
      regWdata <= dt;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] ad, output logic [7:0] q);
      @(posedge clk);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
      #1 q = regRdata;
   endtask

   task automatic start(input logic [7:0] c);
      wr(3'h1, 8'h55);
      wr(3'h1, 8'hAA);
      wr(3'h0, c);
   endtask

   // busy is seen at PROG edges after the launch edge
   task automatic waitIdle(output int n);
      n = 0;
      @(posedge clk);
      #1;
      while (writeBusy !== 1'b0 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 100) begin
         mismatches++;
         stop_test;
      end
   endtask

   task automatic por;
      @(posedge clk);
      nrst <= 1'b0;
      porNrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      porNrst <= 1'b1;
      repeat (PWRT + 2) @(posedge clk);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      stop_test;
   end

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      porNrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), v);
         chk("resetValue", v, 0);
      end
      wr(3'h0, 8'h04);
      start(8'h06);
      rd(3'h0, v);
      chk("pwrtBlocked", progCnt, 0);
      repeat (PWRT) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 10'h3FF : 10'($random(seed));
         wr(3'h3, {6'h3F, a[9:8]});
         wr(3'h2, a[7:0]);
         wr(3'h0, 8'h01);
         rd(3'h3, v);
         chk("addrHigh", v, {6'h00, a[9:8]});
         chk("arrAddr", arrAddr, a);
         rd(3'h4, v);
         chk("readData", v, memf(a));
         rd(3'h0, v);
         chk("readClear", v, 0);
      end
      chk("readCount", readCnt, 8);
      wr(3'h0, 8'h81);
      rd(3'h4, v);
      chk("flashRead", readCnt, 8);
      chk("dataHeld", v, memf(a));
      for (int i = 0; i < 4; i++) begin
         wr(3'h0, {2'(i), 6'h20});
         rd(3'h0, v);
         chk("regionOut", arrRegion, 10'(i));
         chk("ctlRead", v, {2'(i), 6'h00});
      end
      wr(3'h0, 8'h00);
      start(8'h02);
      repeat (2) @(posedge clk);
      chk("noEnable", progCnt, 0);
      start(8'h06);
      repeat (2) @(posedge clk);
      chk("enableAndStart", progCnt, 0);
      wr(3'h0, 8'h04);
      wr(3'h1, 8'h55);
      wr(3'h2, 8'h00);
      wr(3'h1, 8'hAA);
      wr(3'h0, 8'h06);
      repeat (2) @(posedge clk);
      chk("brokenKey", progCnt, 0);
      wr(3'h0, 8'h06);
      repeat (2) @(posedge clk);
      chk("noKey", progCnt, 0);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 8'hFF : 8'($random(seed));
         a = 10'($random(seed));
         wr(3'h3, {6'h00, a[9:8]});
         wr(3'h2, a[7:0]);
         wr(3'h4, d);
         wr(3'h0, 8'h04);
         start(8'h06);
         @(posedge clk);
         #1 chk("busy", writeBusy, 1);
         wr(3'h4, ~d);
         wr(3'h2, ~a[7:0]);
         wr(3'h0, 8'h00);
         chk("progCount", progCnt, 10'(i + 1));
         chk("writeData", arrWdata, d);
         chk("writeAddr", arrAddr, a);
         waitIdle(cyc);
         chk("doneFlag", nvmDoneIrqFlag, 1);
         rd(3'h0, v);
         chk("wrCleared", v, 8'h04);
         rd(3'h4, v);
         chk("dataLocked", v, d);
         @(posedge clk);
         irqFlagClear <= 1'b1;
         @(posedge clk);
         irqFlagClear <= 1'b0;
         @(posedge clk);
         #1 chk("flagCleared", nvmDoneIrqFlag, 0);
      end
      wr(3'h0, 8'h94);
      start(8'h96);
      waitIdle(cyc);
      chk("eraseCycles", cyc, PROG);
      chk("eraseCount", eraseCnt, 1);
      wr(3'h0, 8'h84);
      start(8'h86);
      waitIdle(cyc);
      chk("flashCycles", cyc, PROG);
      chk("flashWrite", progCnt, 5);
      chk("noErase", eraseCnt, 1);
      for (int i = 0; i < 3; i++) begin
         por;
         wr(3'h0, 8'h04);
         @(posedge clk);
         fault <= 3'(1 << i);
         start(8'h06);
         rd(3'h0, v);
         fault <= 3'h0;
         chk("faultFlag", v[3], 1);
         chk("faultNoStart", progCnt, 5);
         chk("faultIdle", writeBusy, 0);
      end
      por;
      wr(3'h0, 8'h04);
      start(8'h06);
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      rd(3'h0, v);
      chk("resetAbort", v[3], 1);
      repeat (PWRT) @(posedge clk);
      rd(3'h0, v);
      chk("flagKept", v[3], 1);
      por;
      rd(3'h0, v);
      chk("porClears", v[3], 0);
      start(8'h08);
      rd(3'h0, v);
      chk("softSet", v[3], 1);
      rd(3'h1, v);
      chk("keyReadZero", v, 0);
      stop_test;
   end
endmodule
